// [core/asis_input_select.sv]
// input-select register of sample sequencer 0 with a step-driven mux output
// assumes AHB-Lite single word transfers and a sequencer that pulses step_start
`timescale 1ns/10ps
`default_nettype none

// Operation
// - step seven converts the input named by bits 25:24.
// - step six converts the input named by bits 21:20.
// - step five converts the input named by bits 17:16, writable, reset zero.
// - step four converts the input named by bits 13:12, writable, reset zero.
// - step three converts the input named by bits 9:8, writable, reset zero.
// - step two converts the input named by bits 5:4, writable, reset zero.
// - step one converts the input named by bits 1:0, writable, reset zero.
// - reserved bit pairs ignore writes and read zero; software keeps them on read-modify-write.
// - a field value is the number of the analog input pin to sample.
module asis_input_select (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        step_start,
  input  wire logic [2:0]  step_index,
  output logic      [1:0]  analog_input_sel,
  output logic      [2:0]  active_step,
  output logic             conv_active
);
  logic [31:0] input_sel;
  logic [31:0] next_input_sel;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [31:0] wr_addr;
  logic [31:0] next_wr_addr;
  logic [31:0] next_hrdata;
  asis_pkg::asis_conv_t conv;
  asis_pkg::asis_conv_t next_conv;
  logic        next_hreadyout;
  logic        next_hresp;
  logic [1:0]  field [0:asis_pkg::ASIS_STEPS-1];
  logic        addr_take;

  // one field per step, step index 0 is the first step
  genvar gi;
  generate
    for (gi = 0; gi < asis_pkg::ASIS_STEPS; gi++)
    begin : g_field
      assign field[gi] = input_sel[gi*asis_pkg::ASIS_FIELD_STRIDE +: 2];
    end
  endgenerate

  assign addr_take = hsel && hready &&
    (htrans == asis_pkg::ASIS_HTRANS_NONSEQ || htrans == asis_pkg::ASIS_HTRANS_SEQ);

  // bus: zero wait state, writes land at the data phase edge
  always_comb
  begin
    next_input_sel = input_sel;
    next_wr_pend   = 1'b0;
    next_wr_addr   = wr_addr;
    next_hrdata    = hrdata;
    if (wr_pend && wr_addr == asis_pkg::ASIS_OFS_INPUT_SEL)
    begin
      // reserved pairs and the eighth field stay zero
      next_input_sel = hwdata & asis_pkg::ASIS_IMPL_MASK;
    end
    if (addr_take)
    begin
      next_wr_pend = hwrite;
      next_wr_addr = {haddr[31:2], 2'b00};
      next_hrdata  = 32'h0000_0000;
      if (!hwrite)
      begin
        unique case ({haddr[31:2], 2'b00})
          asis_pkg::ASIS_OFS_INPUT_SEL: next_hrdata = next_input_sel;
          asis_pkg::ASIS_OFS_STEP_STAT: next_hrdata = {26'h0, conv.active, conv.step,
                                                       conv.input_sel};
          default:                      next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      input_sel <= asis_pkg::ASIS_RESET_INPUT_SEL;
      wr_pend   <= 1'b0;
      wr_addr   <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      input_sel <= next_input_sel;
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
    end
  end

  // conversion step: latch the field only when a step starts
  always_comb
  begin
    next_conv = conv;
    if (step_start)
    begin
      next_conv.active = (int'(step_index) < asis_pkg::ASIS_STEPS);
      next_conv.step   = step_index;
      // field value is the pin number itself, no decoding
      next_conv.input_sel = (int'(step_index) < asis_pkg::ASIS_STEPS) ?
                            field[step_index] : 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      conv <= '0;
    else
      conv <= next_conv;
  end

  // zero wait state, always OKAY; held in flops so the bus pins come from registers
  always_comb
  begin
    next_hreadyout = 1'b1;
    next_hresp     = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= next_hreadyout;
      hresp     <= next_hresp;
    end
  end

  assign analog_input_sel = conv.input_sel;
  assign active_step      = conv.step;
  assign conv_active      = conv.active;

  AST_STEP7: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h6
    |=> analog_input_sel == $past(input_sel[25:24]))
    else $error("step seven picked wrong input");

  AST_STEP6: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h5
    |=> analog_input_sel == $past(input_sel[21:20]))
    else $error("step six picked wrong input");

  AST_STEP5: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h4
    |=> analog_input_sel == $past(input_sel[17:16]))
    else $error("step five picked wrong input");

  AST_STEP4: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h3
    |=> analog_input_sel == $past(input_sel[13:12]))
    else $error("step four picked wrong input");

  AST_STEP3: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h2
    |=> analog_input_sel == $past(input_sel[9:8]))
    else $error("step three picked wrong input");

  AST_STEP2: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h1
    |=> analog_input_sel == $past(input_sel[5:4]))
    else $error("step two picked wrong input");

  AST_STEP1: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h0
    |=> analog_input_sel == $past(input_sel[1:0]))
    else $error("step one picked wrong input");

  AST_PIN_DIRECT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index != 3'h7
    |=> analog_input_sel == $past(field[step_index]))
    else $error("field value not used as pin number");

  AST_IDX8_IDLE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h7
    |=> !conv_active && analog_input_sel == 2'h0)
    else $error("eighth index selected an input");

  AST_STEP_IDX: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start
    |=> active_step == $past(step_index))
    else $error("step index not latched");

  AST_STEP_ACTIVE: assert property (
    @(posedge hclk) disable iff (!hresetn)
    step_start && step_index != 3'h7
    |=> conv_active)
    else $error("valid step not flagged active");

  AST_HOLD_NO_STEP: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !step_start
    |=> $stable(analog_input_sel) && $stable(active_step))
    else $error("selection changed without step start");

  AST_RSVD_ZERO: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (input_sel & ~asis_pkg::ASIS_IMPL_MASK) == 32'h0)
    else $error("reserved bits not zero");

  AST_WRITE_LANDS: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_take && hwrite && haddr[31:2] == 30'h0 ##1 1'b1
    |=> input_sel == ($past(hwdata) & asis_pkg::ASIS_IMPL_MASK))
    else $error("write did not land");

  AST_WR_OTHER_IGNORED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_pend && wr_addr != asis_pkg::ASIS_OFS_INPUT_SEL
    |=> $stable(input_sel))
    else $error("write elsewhere changed the register");

  AST_NO_WR_HOLD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !wr_pend
    |=> $stable(input_sel))
    else $error("register changed without a write");

  AST_RD_SEL: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[31:2] == 30'h0 && !wr_pend
    |=> hrdata == $past(input_sel))
    else $error("read of select register wrong");

  AST_RD_AFTER_WR: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[31:2] == 30'h0 && wr_pend && wr_addr == 32'h0
    |=> hrdata == ($past(hwdata) & asis_pkg::ASIS_IMPL_MASK))
    else $error("read after write missed new value");

  AST_RD_RSVD_WORD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[31:2] == 30'h1
    |=> hrdata == 32'h0)
    else $error("reserved word read not zero");

  AST_RD_UNMAPPED: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[31:2] > 30'h2
    |=> hrdata == 32'h0)
    else $error("unmapped read not zero");

  AST_RD_STAT: assert property (
    @(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[31:2] == 30'h2
    |=> hrdata == {26'h0, $past(conv_active), $past(active_step), $past(analog_input_sel)})
    else $error("step status read wrong");

  AST_RD_HOLD: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !addr_take
    |=> $stable(hrdata))
    else $error("read data moved outside an access");

  AST_BUS_OKAY: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp)
    else $error("bus not ready or not okay");

  COV_WRITE: cover property (@(posedge hclk) disable iff (!hresetn)
    addr_take && hwrite && haddr[31:2] == 30'h0);
  COV_READ: cover property (@(posedge hclk) disable iff (!hresetn)
    addr_take && !hwrite && haddr[31:2] == 30'h0);
  COV_STEP7: cover property (@(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h6 && input_sel[25:24] == 2'h3);
  COV_WR_THEN_STEP: cover property (@(posedge hclk) disable iff (!hresetn)
    wr_pend ##1 step_start);
  COV_IDX8: cover property (@(posedge hclk) disable iff (!hresetn)
    step_start && step_index == 3'h7);
endmodule

`default_nettype wire

// [common/asis_pkg.sv]
// package for the sequence-0 input-select block
// assumes a single AHB-Lite slave behind a 32-bit data bus
package asis_pkg;
  localparam logic [31:0] ASIS_OFS_INPUT_SEL  = 32'h0000_0000;
  localparam logic [31:0] ASIS_OFS_STEP_CTRL  = 32'h0000_0004;
  localparam logic [31:0] ASIS_OFS_STEP_STAT  = 32'h0000_0008;
  localparam logic [31:0] ASIS_RESET_INPUT_SEL = 32'h0000_0000;
  // writable bits: fields at 1:0, 5:4, 9:8, 13:12, 17:16, 21:20, 25:24; writes go through ASIS_IMPL_MASK, so 29:28 is not writable
  localparam logic [31:0] ASIS_WRITE_MASK    = 32'h3333_3333;
  // the eighth field is out of scope and held at zero
  localparam logic [31:0] ASIS_IMPL_MASK     = 32'h0333_3333;
  localparam int          ASIS_FIELD_STRIDE  = 4;
  localparam int          ASIS_STEPS         = 7;
  localparam logic [1:0]  ASIS_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  ASIS_HTRANS_SEQ    = 2'h3;

  typedef struct packed {
    logic [2:0] step;
    logic [1:0] input_sel;
    logic       active;
  } asis_conv_t;
endpackage

// [tb/asis_input_select_tb.sv]
// self-checking bench for the sequence-0 input-select register and step mux
// assumes one master; the slave's hreadyout is fed back as its own hready
`timescale 1ns/10ps
`default_nettype none
module asis_input_select_tb;
  logic        hclk, hresetn, hsel, hwrite, step_start, hreadyout, hresp, conv_active;
  logic [31:0] haddr, hwdata, hrdata, m, v, r;
  logic [1:0]  htrans, analog_input_sel;
  logic [2:0]  hsize, step_index, active_step;
  integer      failures, checks, seed, i, k;

  asis_input_select u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .step_start(step_start),
    .step_index(step_index), .analog_input_sel(analog_input_sel),
    .active_step(active_step), .conv_active(conv_active));

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single word transfer; read data taken at the edge that ends the data phase
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= asis_pkg::ASIS_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk(hresp, 32'h0);
  endtask

  // a step pulse; the mux output is looked at once the latching edge has landed
  task step(input integer j);
    @(posedge hclk);
    step_start <= 1'b1;
    step_index <= j[2:0];
    @(posedge hclk);
    step_start <= 1'b0;
    #1;
    if (j < 7)
      chk(analog_input_sel, (m >> (4 * j)) & 32'h3);
    else
      chk(analog_input_sel, 32'h0);
    chk(active_step, j);
    chk(conv_active, j < 7);
  endtask

  task close_out;
    $display("mismatches %0d of %0d comparisons", failures, checks);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    #300000;
    failures++;
    close_out;
  end

  initial
  begin
    failures = 0; checks = 0; seed = 32'h292fd66e; m = 32'h0;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; step_start = 1'b0; step_index = 3'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk({conv_active, active_step, analog_input_sel}, 32'h0);
    xfer(1'b0, asis_pkg::ASIS_OFS_INPUT_SEL, 32'h0);
    chk(r, asis_pkg::ASIS_RESET_INPUT_SEL);
    for (i = 0; i < 12; i++)
    begin
      v = $random(seed);
      xfer(1'b1, asis_pkg::ASIS_OFS_INPUT_SEL, v);
      m = v & 32'h0333_3333;
      xfer(1'b0, asis_pkg::ASIS_OFS_INPUT_SEL, 32'h0);
      chk(r, m);
      for (k = 0; k < 8; k++)
        step(k);
    end
    // reserved word: a write vanishes and reads give zero; an unmapped place is only read and gives zero
    xfer(1'b1, asis_pkg::ASIS_OFS_STEP_CTRL, $random(seed));
    xfer(1'b0, asis_pkg::ASIS_OFS_STEP_CTRL, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 32'h0000_0010, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, asis_pkg::ASIS_OFS_INPUT_SEL, 32'h0);
    chk(r, m);
    // a write after a step started must not disturb that step
    step(2);
    xfer(1'b1, asis_pkg::ASIS_OFS_INPUT_SEL, ~m);
    #1;
    chk(analog_input_sel, (m >> 8) & 32'h3);
    m = ~m & 32'h0333_3333;
    step(2);
    xfer(1'b0, asis_pkg::ASIS_OFS_STEP_STAT, 32'h0);
    chk(r, {26'h0, 1'b1, 3'h2, m[9:8]});
    close_out;
  end
endmodule
`default_nettype wire
